// >>> vc_sync_pkg.sv
// Package with constants and types for the voltage/current sample synchroniser.
package vc_sync_pkg;
    localparam int SYS_CLOCK_HZ = 25000000;
    localparam int SUBSYS_CLOCK_HZ = 6000000;
    localparam int SAR_CLOCK_HZ = 3000000;
    localparam int SUBSYS_DIV = SYS_CLOCK_HZ / SUBSYS_CLOCK_HZ;
    localparam int SAR_DIV = SYS_CLOCK_HZ / SAR_CLOCK_HZ;
    localparam int SINC_OSR = 128;
    localparam int INTEGRATOR_OSR = 8;
    localparam int EFFECTIVE_OSR = SINC_OSR * INTEGRATOR_OSR;
    localparam int HOLD_CYCLES = 4;
    localparam int CONVERT_CYCLES = 16;
    localparam int CHANNEL_CYCLES = HOLD_CYCLES + CONVERT_CYCLES;
    localparam int RISE_COMPARE = 512;
    localparam int NUM_CHANNELS = 3;
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_PERIOD = 8'h08;
    localparam logic [7:0] ADDR_PHASE_A = 8'h0C;
    localparam logic [7:0] ADDR_PHASE_B = 8'h10;
    localparam logic [7:0] ADDR_PHASE_C = 8'h14;
    localparam logic [7:0] ADDR_SPI_TX = 8'h18;
    localparam logic [7:0] ADDR_SPI_RX = 8'h1C;
    localparam int CTRL_START = 0;
    localparam int CTRL_SAR_READY = 1;
    localparam int CTRL_FILTER_READY = 2;
    localparam int CTRL_CLR_SCAN = 3;
    localparam int CTRL_CLR_PKT = 4;
    localparam int CTRL_IRQ_EN = 5;
    localparam logic [1:0] PHASE_A_CH = 2'h2;
    localparam logic [1:0] PHASE_B_CH = 2'h1;
    localparam logic [1:0] PHASE_C_CH = 2'h0;

    typedef enum logic [1:0] {
        SEQ_SETUP_SAR = 2'b00,
        SEQ_SETUP_FILTER = 2'b01,
        SEQ_WAIT_START = 2'b11,
        SEQ_RUNNING = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic sclk;
        logic mosi;
        logic mod_clk;
        logic trig;
    } link_out_t;
endpackage : vc_sync_pkg

// >>> voltage_current_sample_sync.sv
// Trigger timer, voltage scan sequencer and filter link for synchronised sampling.
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps
module voltage_current_sample_sync
    import vc_sync_pkg::*;
#(
    parameter int PERIOD = EFFECTIVE_OSR,
    parameter int SAR_BITS = 14
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Register port.
    input wire vc_sync_pkg::reg_req_t req,
    output logic [31:0] rdata,
    // Voltage converter sample input.
    input wire logic [SAR_BITS-1:0] sar_sample,
    output logic [1:0] sar_channel,
    // Filter link.
    input wire logic filter_miso,
    input wire logic sample_ready,
    output vc_sync_pkg::link_out_t link,
    // Events.
    output logic scan_irq,
    output logic packet_irq
);
    import vc_sync_pkg::*;

    logic [2:0] sub_div_reg;
    logic sub_en;
    logic [3:0] sar_div_reg;
    logic sar_en;
    logic mod_clk_reg;
    seq_state_t state_reg;
    logic running_reg;
    logic [10:0] count_reg;
    logic trig_reg;
    logic trig_dly_reg;
    logic scan_active_reg;
    logic [1:0] scan_idx_reg;
    logic [4:0] phase_cnt_reg;
    logic [15:0] result_reg [NUM_CHANNELS];
    logic scan_flag_reg;
    logic packet_flag_reg;
    logic irq_en_reg;
    logic [7:0] tx_reg;
    logic [7:0] rx_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic spi_busy_reg;
    logic sclk_reg;
    logic ready_dly_reg;
    logic start_req;
    logic scan_done;
    logic packet_done;
    logic [10:0] last_count;

    function automatic logic [15:0] scale_signed(input logic [SAR_BITS-1:0] raw);
        logic [15:0] wide;
        wide = 16'h0000;
        wide[15 -: SAR_BITS] = raw;
        scale_signed = wide ^ 16'h8000;
    endfunction : scale_signed

    assign last_count = 11'(PERIOD - 1);
    assign start_req = req.wr && (req.addr == ADDR_CONTROL) && req.wdata[CTRL_START];

    // Four system clocks make one subsystem clock, the nearest whole divide for 6 MHz.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sub_div_reg <= 3'h0;
        end else if (sub_div_reg == 3'(SUBSYS_DIV - 1)) begin
            sub_div_reg <= 3'h0;
        end else begin
            sub_div_reg <= sub_div_reg + 3'h1;
        end
    end
    assign sub_en = (sub_div_reg == 3'(SUBSYS_DIV - 1));

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sar_div_reg <= 4'h0;
        end else if (sar_div_reg == 4'(SAR_DIV - 1)) begin
            sar_div_reg <= 4'h0;
        end else begin
            sar_div_reg <= sar_div_reg + 4'h1;
        end
    end
    assign sar_en = (sar_div_reg == 4'(SAR_DIV - 1));

    // Setup sequencer: converter ready, then filter ready, then start.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= SEQ_SETUP_SAR;
        end else if (req.wr && req.addr == ADDR_CONTROL) begin
            case (state_reg)
                SEQ_SETUP_SAR: begin
                    if (req.wdata[CTRL_SAR_READY]) begin
                        state_reg <= SEQ_SETUP_FILTER;
                    end
                end
                SEQ_SETUP_FILTER: begin
                    if (req.wdata[CTRL_FILTER_READY]) begin
                        state_reg <= SEQ_WAIT_START;
                    end
                end
                SEQ_WAIT_START: begin
                    if (start_req) begin
                        state_reg <= SEQ_RUNNING;
                    end
                end
                SEQ_RUNNING: state_reg <= SEQ_RUNNING;
                default: state_reg <= SEQ_SETUP_SAR;
            endcase
        end
    end

    // One flag starts both the timer and the modulator clock route.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            running_reg <= 1'b0;
        end else if (state_reg == SEQ_RUNNING && sub_en) begin
            running_reg <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            mod_clk_reg <= 1'b0;
        end else if (!running_reg) begin
            mod_clk_reg <= 1'b0;
        end else if (sub_div_reg == 3'h0 || sub_div_reg == 3'h2) begin
            mod_clk_reg <= ~mod_clk_reg;
        end
    end

    // Trigger timer with two compares.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_reg <= 11'h000;
        end else if (running_reg && sub_en) begin
            count_reg <= (count_reg == last_count) ? 11'h000 : count_reg + 11'h001;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            trig_reg <= 1'b0;
        end else if (running_reg && sub_en) begin
            if (count_reg == last_count) begin
                trig_reg <= 1'b0;
            end else if (count_reg == 11'(RISE_COMPARE - 1)) begin
                trig_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            trig_dly_reg <= 1'b0;
        end else begin
            trig_dly_reg <= trig_reg;
        end
    end

    // Scan sequencer: 60 converter clocks fit easily in one 1024-cycle period.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scan_active_reg <= 1'b0;
            scan_idx_reg <= 2'h0;
            phase_cnt_reg <= 5'h00;
        end else if (trig_reg && !trig_dly_reg) begin
            scan_active_reg <= 1'b1;
            scan_idx_reg <= 2'h0;
            phase_cnt_reg <= 5'h00;
        end else if (scan_active_reg && sar_en) begin
            if (phase_cnt_reg == 5'(CHANNEL_CYCLES - 1)) begin
                phase_cnt_reg <= 5'h00;
                if (scan_idx_reg == 2'(NUM_CHANNELS - 1)) begin
                    scan_active_reg <= 1'b0;
                end else begin
                    scan_idx_reg <= scan_idx_reg + 2'h1;
                end
            end else begin
                phase_cnt_reg <= phase_cnt_reg + 5'h01;
            end
        end
    end

    assign scan_done = scan_active_reg && sar_en && scan_idx_reg == 2'(NUM_CHANNELS - 1)
        && phase_cnt_reg == 5'(CHANNEL_CYCLES - 1);

    always_comb begin
        case (scan_idx_reg)
            2'h0: sar_channel = PHASE_A_CH;
            2'h1: sar_channel = PHASE_B_CH;
            default: sar_channel = PHASE_C_CH;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_CHANNELS; i++) begin
                result_reg[i] <= 16'h0000;
            end
        end else if (scan_active_reg && sar_en && phase_cnt_reg == 5'(CHANNEL_CYCLES - 1)) begin
            result_reg[scan_idx_reg] <= scale_signed(sar_sample);
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scan_flag_reg <= 1'b0;
        end else if (scan_done) begin
            scan_flag_reg <= 1'b1;
        end else if (req.wr && req.addr == ADDR_CONTROL && req.wdata[CTRL_CLR_SCAN]) begin
            scan_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            irq_en_reg <= 1'b0;
        end else if (req.wr && req.addr == ADDR_CONTROL) begin
            irq_en_reg <= req.wdata[CTRL_IRQ_EN];
        end
    end

    // Serial link: transmit channel shifts out, receive channel shifts in.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tx_reg <= 8'h00;
            shift_reg <= 8'h00;
            bit_cnt_reg <= 4'h0;
            spi_busy_reg <= 1'b0;
            sclk_reg <= 1'b0;
            rx_reg <= 8'h00;
        end else if (req.wr && req.addr == ADDR_SPI_TX && !spi_busy_reg) begin
            tx_reg <= req.wdata[7:0];
            shift_reg <= req.wdata[7:0];
            bit_cnt_reg <= 4'h0;
            spi_busy_reg <= 1'b1;
        end else if (spi_busy_reg && sub_en) begin
            sclk_reg <= ~sclk_reg;
            if (sclk_reg) begin
                shift_reg <= {shift_reg[6:0], filter_miso};
                if (bit_cnt_reg == 4'h7) begin
                    spi_busy_reg <= 1'b0;
                    rx_reg <= {shift_reg[6:0], filter_miso};
                end
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
        end
    end

    assign packet_done = spi_busy_reg && sub_en && sclk_reg && bit_cnt_reg == 4'h7;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            packet_flag_reg <= 1'b0;
        end else if (packet_done) begin
            packet_flag_reg <= 1'b1;
        end else if (req.wr && req.addr == ADDR_CONTROL && req.wdata[CTRL_CLR_PKT]) begin
            packet_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ready_dly_reg <= 1'b0;
        end else begin
            ready_dly_reg <= sample_ready;
        end
    end

    assign scan_irq = scan_flag_reg & irq_en_reg;
    assign packet_irq = packet_flag_reg & irq_en_reg;
    assign link = '{sclk: sclk_reg, mosi: shift_reg[7], mod_clk: mod_clk_reg,
        trig: trig_reg};

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata <= 32'h0000_0000;
        end else if (req.rd) begin
            case (req.addr)
                ADDR_CONTROL: rdata <= {26'h0, irq_en_reg, 5'h00};
                ADDR_STATUS: rdata <= {24'h0, sample_ready && !ready_dly_reg, spi_busy_reg,
                    packet_flag_reg, scan_flag_reg, scan_active_reg, running_reg, state_reg};
                ADDR_PERIOD: rdata <= {21'h0, count_reg};
                ADDR_PHASE_A: rdata <= {16'h0, result_reg[0]};
                ADDR_PHASE_B: rdata <= {16'h0, result_reg[1]};
                ADDR_PHASE_C: rdata <= {16'h0, result_reg[2]};
                ADDR_SPI_TX: rdata <= {24'h0, tx_reg};
                ADDR_SPI_RX: rdata <= {24'h0, rx_reg};
                default: rdata <= 32'h0000_0000;
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

    property p_reset_idle;
        @(posedge clock) disable iff (!resetn) !running_reg |-> (!trig_reg && !mod_clk_reg);
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("idle outputs active");

    property p_fall_at_wrap;
        @(posedge clock) disable iff (!resetn)
            (running_reg && sub_en && count_reg == last_count) |=> !trig_reg;
    endproperty
    a_fall_at_wrap: assert property (p_fall_at_wrap) else $error("trigger not low at wrap");

    property p_rise_point;
        @(posedge clock) disable iff (!resetn)
            $rose(trig_reg) |-> $past(count_reg) == 11'(RISE_COMPARE - 1);
    endproperty
    a_rise_point: assert property (p_rise_point) else $error("trigger rose off compare");

    property p_wrap;
        @(posedge clock) disable iff (!resetn)
            (running_reg && sub_en && count_reg == last_count) |=> count_reg == 11'h000;
    endproperty
    a_wrap: assert property (p_wrap) else $error("timer did not restart");

    property p_stopped;
        @(posedge clock) disable iff (!resetn) state_reg != SEQ_RUNNING |-> !running_reg;
    endproperty
    a_stopped: assert property (p_stopped) else $error("timer started early");

    sequence s_trigger_rise;
        trig_reg && !trig_dly_reg;
    endsequence
    property p_scan_starts;
        @(posedge clock) disable iff (!resetn) s_trigger_rise |=> scan_active_reg;
    endproperty
    a_scan_starts: assert property (p_scan_starts) else $error("scan not started");

    property p_scan_irq;
        @(posedge clock) disable iff (!resetn) scan_done |=> scan_flag_reg;
    endproperty
    a_scan_irq: assert property (p_scan_irq) else $error("scan flag lost");

    property p_packet_irq;
        @(posedge clock) disable iff (!resetn) packet_done |=> packet_flag_reg;
    endproperty
    a_packet_irq: assert property (p_packet_irq) else $error("packet flag lost");

    // The previous scan must be over by the time the next trigger rises.
    property p_scan_in_period;
        @(posedge clock) disable iff (!resetn) s_trigger_rise |-> !scan_active_reg;
    endproperty
    a_scan_in_period: assert property (p_scan_in_period) else $error("scan overran");
endmodule : voltage_current_sample_sync

// >>> filter_link_model.sv
// Behavioural model of the standalone filter on the far side of the serial link.
`timescale 1ns/1ps
module filter_link_model #(
    parameter int EFFECTIVE_OVERSAMPLING_RATIO = 64,
    parameter logic [7:0] FIRST_REPLY = 8'hC3
) (
    // Clock and reset.
    input wire logic clock,
    input wire logic resetn,
    // Link from the host.
    input wire logic sclk,
    input wire logic mosi,
    input wire logic mod_clk,
    // Link to the host.
    output logic miso,
    output logic sample_ready,
    output logic [7:0] last_rx
);
    logic sclk_d;
    logic mod_d;
    logic [7:0] shift_in;
    logic [7:0] reply;
    logic [2:0] fall_cnt;
    int mod_cnt;

    // The reply is shifted out msb first; the first frame sends FIRST_REPLY, each later frame echoes the byte of the previous one.
    assign miso = reply[3'h7 - fall_cnt];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sclk_d <= 1'b0;
            mod_d <= 1'b0;
            shift_in <= 8'h00;
            reply <= FIRST_REPLY;
            fall_cnt <= 3'h0;
            mod_cnt <= 0;
            sample_ready <= 1'b0;
            last_rx <= 8'h00;
        end else begin
            sclk_d <= sclk;
            mod_d <= mod_clk;
            if (sclk && !sclk_d) begin
                shift_in <= {shift_in[6:0], mosi};
            end
            if (mod_clk && !mod_d) begin
                if (mod_cnt == EFFECTIVE_OVERSAMPLING_RATIO - 1) begin
                    mod_cnt <= 0;
                    sample_ready <= 1'b1;
                end else begin
                    mod_cnt <= mod_cnt + 1;
                end
            end
            if (!sclk && sclk_d) begin
                fall_cnt <= fall_cnt + 3'h1;
                if (fall_cnt == 3'h7) begin
                    reply <= shift_in;
                    last_rx <= shift_in;
                    sample_ready <= 1'b0;
                end
            end
        end
    end
endmodule : filter_link_model

// >>> voltage_current_sample_sync_tb.sv
// Self-checking testbench for the voltage and current sample synchroniser.
`timescale 1ns/1ps
module voltage_current_sample_sync_tb;
    import vc_sync_pkg::*;
    localparam int PERIOD_TB = 520;
    localparam int SCAN_NOM = NUM_CHANNELS * CHANNEL_CYCLES * SAR_DIV;
    logic clock;
    logic resetn;
    reg_req_t req;
    logic [31:0] rdata;
    logic [13:0] sar_sample;
    logic [1:0] sar_channel;
    logic filter_miso;
    logic sample_ready;
    link_out_t link;
    logic scan_irq;
    logic packet_irq;
    logic [7:0] model_rx;
    logic [13:0] codes [4];
    int errors;
    int samples_checked;
    int n;
    int m;

    // The converter input follows the selected channel.
    assign sar_sample = codes[sar_channel];

    voltage_current_sample_sync #(.PERIOD(PERIOD_TB), .SAR_BITS(14)) u_dut (
        .clock(clock),
        .resetn(resetn),
        .req(req),
        .rdata(rdata),
        .sar_sample(sar_sample),
        .sar_channel(sar_channel),
        .filter_miso(filter_miso),
        .sample_ready(sample_ready),
        .link(link),
        .scan_irq(scan_irq),
        .packet_irq(packet_irq)
    );

    filter_link_model #(.EFFECTIVE_OVERSAMPLING_RATIO(64), .FIRST_REPLY(8'hC3)) u_filter (
        .clock(clock),
        .resetn(resetn),
        .sclk(link.sclk),
        .mosi(link.mosi),
        .mod_clk(link.mod_clk),
        .miso(filter_miso),
        .sample_ready(sample_ready),
        .last_rx(model_rx)
    );

    task automatic report_and_stop;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
        @(posedge clock);
        #1;
    endtask : wr

    task automatic rdx(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b0};
        #1;
        check(rdata & mask, exp);
    endtask : rdx

    // Waits for a design or model signal to reach a level; n returns the cycles taken.
    task automatic wait_lvl(input int which, input logic lvl, input int bound);
        logic s;
        s = ~lvl;
        n = 0;
        while (s !== lvl && n < bound) begin
            @(posedge clock);
            #1;
            n++;
            case (which)
                0: s = link.trig;
                1: s = scan_irq;
                2: s = packet_irq;
                3: s = sample_ready;
                default: s = link.mod_clk;
            endcase
        end
        if (s !== lvl) begin
            errors++;
            $display("mismatch at %0t ns: wait %0d got %h expected %h", $time, which, s, lvl);
            report_and_stop();
        end
    endtask : wait_lvl

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    initial begin
        resetn = 1'b0;
        req = '0;
        errors = 0;
        samples_checked = 0;
        codes[0] = 14'h3FFF;
        codes[1] = 14'h0123;
        codes[2] = 14'h1ABC;
        codes[3] = 14'h0000;
        repeat (8) @(posedge clock);
        #1;
        check({26'h0, link, scan_irq, packet_irq}, 32'h0);
        resetn <= 1'b1;
        @(posedge clock);
        #1;
        rdx(ADDR_STATUS, 32'hF, 32'h0);
        rdx(ADDR_PERIOD, 32'hFFFFFFFF, 32'h0);
        rdx(8'hFC, 32'hFFFFFFFF, 32'h0);
        // A start before both sides are ready must be ignored.
        wr(ADDR_CONTROL, 32'h21);
        rdx(ADDR_STATUS, 32'hF, 32'h0);
        wr(ADDR_CONTROL, 32'h22);
        rdx(ADDR_STATUS, 32'hF, 32'h1);
        wr(ADDR_CONTROL, 32'h24);
        rdx(ADDR_STATUS, 32'hF, 32'h3);
        rdx(ADDR_PERIOD, 32'hFFFFFFFF, 32'h0);
        check({30'h0, link.mod_clk, link.trig}, 32'h0);
        wr(ADDR_CONTROL, 32'h21);
        rdx(ADDR_STATUS, 32'h7, 32'h6);
        rdx(ADDR_CONTROL, 32'hFFFFFFFF, 32'h20);
        wait_lvl(4, 1'b1, 4 * SUBSYS_DIV + 8);
        // Trigger pulse shape and period.
        wait_lvl(0, 1'b1, PERIOD_TB * SUBSYS_DIV + 8);
        wait_lvl(0, 1'b0, PERIOD_TB * SUBSYS_DIV);
        m = n;
        check(32'(m), 32'((PERIOD_TB - RISE_COMPARE) * SUBSYS_DIV));
        wait_lvl(0, 1'b1, PERIOD_TB * SUBSYS_DIV);
        check(32'(m + n), 32'(PERIOD_TB * SUBSYS_DIV));
        // One full scan per trigger, timed from the rising edge.
        wait_lvl(1, 1'b1, PERIOD_TB * SUBSYS_DIV);
        wr(ADDR_CONTROL, 32'h28);
        check({31'h0, scan_irq}, 32'h0);
        wait_lvl(0, 1'b1, PERIOD_TB * SUBSYS_DIV);
        wait_lvl(1, 1'b1, PERIOD_TB * SUBSYS_DIV);
        check(32'(n >= SCAN_NOM - SAR_DIV && n <= SCAN_NOM + 2 * SAR_DIV), 32'h1);
        check(32'(n < (PERIOD_TB - RISE_COMPARE) * SUBSYS_DIV + SCAN_NOM), 32'h1);
        rdx(ADDR_STATUS, 32'h10, 32'h10);
        for (int i = 0; i < 3; i++) begin
            rdx(ADDR_PHASE_A + 8'(4 * i), 32'hFFFF, {16'h0, {codes[2 - i], 2'b00} ^ 16'h8000});
        end
        // Serial link transfers, the second with a write refused while busy.
        wr(ADDR_SPI_TX, 32'h5A);
        rdx(ADDR_STATUS, 32'h40, 32'h40);
        wait_lvl(2, 1'b1, 64 * SUBSYS_DIV);
        // The filter drops sample-ready at the frame end; the status bit marks its next rise.
        wait_lvl(3, 1'b0, 4);
        wait_lvl(3, 1'b1, 4096);
        rdx(ADDR_STATUS, 32'h80, 32'h80);
        check({24'h0, model_rx}, 32'h5A);
        rdx(ADDR_SPI_RX, 32'hFF, 32'hC3);
        rdx(ADDR_SPI_TX, 32'hFF, 32'h5A);
        wr(ADDR_CONTROL, 32'h30);
        check({31'h0, packet_irq}, 32'h0);
        wr(ADDR_SPI_TX, 32'h3C);
        wr(ADDR_SPI_TX, 32'hFF);
        wait_lvl(2, 1'b1, 64 * SUBSYS_DIV);
        // The model takes the last byte one clock after the host flags the packet.
        rdx(ADDR_SPI_RX, 32'hFF, 32'h5A);
        check({24'h0, model_rx}, 32'h3C);
        rdx(ADDR_SPI_TX, 32'hFF, 32'h3C);
        report_and_stop();
    end
endmodule : voltage_current_sample_sync_tb
